/* File: dv/adapter_error_summary_assertions.sv */
/*
 * Port-level checks of the error summary block's fallback answers.
 * Assumes binding to the top module; event inputs are one-cycle pulses.
 */
`default_nettype none

module adapter_error_summary_assertions (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic loopback_mode,
	input wire logic loopback_wr_parity_err,
	input wire logic loopback_rd_parity_err,
	input wire logic io_rd_parity_err,
	input wire logic io_rd_is_ident,
	input wire logic loopback_wr_abort,
	input wire logic loopback_rd_abort,
	input wire logic read_error_response,
	input wire logic ident_vector_valid,
	input wire logic vectored_error_interrupt,
	input wire logic [3:0] write_error_type_code
);
	// one clock domain, so shared clocking and disable
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	AST_RD_ERR: assert property (io_rd_parity_err && !io_rd_is_ident |=> read_error_response)
		else $error("read error response missing");
	AST_RD_CAUSE: assert property (read_error_response |-> $past(io_rd_parity_err && !io_rd_is_ident))
		else $error("read error response without cause");
	AST_IDENT: assert property (io_rd_parity_err && io_rd_is_ident |=> ident_vector_valid)
		else $error("identify fallback vector missing");
	AST_IDENT_ONCE: assert property (ident_vector_valid |=> !ident_vector_valid || $past(io_rd_parity_err))
		else $error("identify vector pulse too long");
	AST_LB_WR: assert property (loopback_mode && loopback_wr_parity_err |=> loopback_wr_abort)
		else $error("loopback write not aborted");
	AST_LB_CAUSE: assert property (loopback_wr_abort |-> $past(loopback_mode && loopback_wr_parity_err))
		else $error("loopback write abort without cause");
	AST_LB_RD: assert property (loopback_mode && loopback_rd_parity_err |=> loopback_rd_abort)
		else $error("loopback read not aborted");
	AST_VEC_CODE: assert property (vectored_error_interrupt |-> write_error_type_code == 4'h1)
		else $error("vectored interrupt without write error type");
endmodule

bind adapter_error_summary adapter_error_summary_assertions adapter_error_summary_assertions_inst (.*);

`default_nettype wire

/* File: dv/test_adapter_error_summary.sv */
/*
 * Self-checking bench of the error summary block with AHB-Lite tasks.
 * Assumes zero-wait answers may vary; every wait is bounded by the timeout.
 */
`default_nettype none

module test_adapter_error_summary;
	timeunit 1ns;
	timeprecision 1ns;
	logic hclk, hresetn, hsel, hwrite, loopback_mode, vme_power_fail_input_n;
	logic chan_a_xfer_is_write, chan_b_xfer_is_write, io_rd_is_ident;
	logic [11:0] haddr;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] hwdata, io_wr_addr, rd, m, a1, seed;
	logic [7:0] e;
	logic [14:0] ev;
	wire logic [31:0] hrdata;
	wire logic hreadyout, hready, hresp, loopback_wr_abort, loopback_rd_abort, error_irq;
	wire logic read_error_response, ident_vector_valid, vectored_error_interrupt;
	wire logic [15:0] ident_vector;
	wire logic [3:0] write_error_type_code;
	wire logic ctrl_fsm_illegal, page_map_ram_wr_parity_err, loopback_wr_parity_err;
	wire logic loopback_rd_parity_err, io_wr_fail, chan_a_data_parity_err, io_wr_start;
	wire logic chan_a_cmdaddr_parity_err, chan_b_data_parity_err, chan_b_cmdaddr_parity_err;
	wire logic io_rd_parity_err, power_up_event, node_reset_request, diag_reset_request;
	wire logic vme_boot_reset;
	int error_cnt = 0, n_compared = 0, cyc = 0, i;
	logic [7:0] exp_st [14] = '{8'h80, 8'hc0, 8'hc0, 8'h80, 8'h40, 8'h10, 8'h08,
		8'h04, 8'h02, 8'h01, 8'h20, 8'h20, 8'h20, 8'h20};

	// single slave, so its ready is the bus ready
	assign hready = hreadyout;
	assign {io_wr_start, vme_boot_reset, diag_reset_request, node_reset_request,
		power_up_event, io_rd_parity_err, chan_b_cmdaddr_parity_err, chan_b_data_parity_err,
		chan_a_cmdaddr_parity_err, chan_a_data_parity_err, io_wr_fail, loopback_rd_parity_err,
		loopback_wr_parity_err, page_map_ram_wr_parity_err, ctrl_fsm_illegal} = ev;

	adapter_error_summary adapter_error_summary_inst (.*);
	vme_side_model vme_side_model_inst (.hclk(hclk), .ev(ev));

	// free-running clock, 100 ns period
	initial begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// vectored request expected from the flags and the mask written
	function automatic logic exp_vec(input logic [7:0] f, input logic [31:0] mk);
		return mk[31] & ((|(f & 8'hf4)) | (f[3] & mk[8]) | (f[1] & mk[9]));
	endfunction

	task automatic give_verdict;
		$display("errors %0d compared %0d", error_cnt, n_compared);
		if (error_cnt == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// single transfer: address phase, then data phase; waits on ready
	task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	// hang guard well above the expected run length
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			give_verdict();
		end
	end

	initial begin
		seed = 32'hcffc;
		{hresetn, hsel, hwrite, htrans, haddr, hwdata, loopback_mode} = '0;
		{chan_a_xfer_is_write, chan_b_xfer_is_write, io_rd_is_ident, io_wr_addr} = '0;
		hsize = 3'h2;
		vme_power_fail_input_n = 1'b1;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		ahb(0, 12'h000, 0);
		check(rd, 32'h20);
		ahb(1, 12'h000, 32'h0);
		ahb(0, 12'h000, 0);
		check(rd, 32'h20);
		ahb(1, 12'h000, 32'h20);
		ahb(0, 12'h000, 0);
		check(rd, 32'h0);
		// every event source, random mask and transfer direction
		for (i = 0; i < 14; i++) begin
			m = $random(seed);
			// loopback parity events only count in loopback mode
			e = ((i == 2 || i == 3) && !m[11]) ? 8'h00 : exp_st[i];
			chan_a_xfer_is_write <= m[8];
			chan_b_xfer_is_write <= m[9];
			loopback_mode <= m[11];
			io_rd_is_ident <= m[12];
			ahb(1, 12'h004, m);
			vme_side_model_inst.fire(i);
			// one-cycle answers stand until the next edge, look mid-cycle
			@(negedge hclk);
			check({hresp, hreadyout, loopback_wr_abort, loopback_rd_abort, read_error_response,
				ident_vector_valid}, {2'b01, (i == 2) & m[11], (i == 3) & m[11],
				(i == 9) & !m[12], (i == 9) & m[12]});
			repeat (3) @(posedge hclk);
			check(vectored_error_interrupt, exp_vec(e, m));
			check(write_error_type_code, exp_vec(e, m) ? 4'h1 : 4'h0);
			check(error_irq, |(e[3:0] & m[3:0] & 4'hb));
			ahb(0, 12'h000, 0);
			check(rd, e);
			ahb(1, 12'h000, 32'hff);
		end
		// loopback write error ignored outside loopback mode
		loopback_mode <= 1'b0;
		vme_side_model_inst.fire(2);
		ahb(0, 12'h000, 0);
		check(rd, 32'h0);
		// new event lands in the same cycle as the clearing write
		fork
			ahb(1, 12'h000, 32'hff);
			begin
				@(posedge hclk);
				vme_side_model_inst.fire(5);
			end
		join
		ahb(0, 12'h000, 0);
		check(rd, 32'h10);
		// failing write locks the responder error address
		a1 = $random(seed);
		io_wr_addr <= a1;
		vme_side_model_inst.fire(14);
		vme_side_model_inst.fire(4);
		io_wr_addr <= ~a1;
		vme_side_model_inst.fire(14);
		ahb(0, 12'h00c, 0);
		check(rd, a1);
		// identify parity error returns the return vector
		ahb(1, 12'h008, a1);
		io_rd_is_ident <= 1'b1;
		vme_side_model_inst.fire(9);
		repeat (2) @(posedge hclk);
		check(ident_vector, a1[15:0]);
		// power-fail pin through the synchroniser
		ahb(1, 12'h000, 32'hff);
		ahb(1, 12'h004, 32'h80000000);
		vme_power_fail_input_n <= 1'b0;
		repeat (8) @(posedge hclk);
		check(vectored_error_interrupt, 1'b1);
		ahb(0, 12'h000, 0);
		check(rd, 32'h20);
		give_verdict();
	end
endmodule

`default_nettype wire

/* File: dv/vme_side_model.sv */
/*
 * Far-side model: VME-side module and event sources as one-cycle pulses.
 * Assumes fire is called just after a rising edge of hclk.
 */
`default_nettype none

module vme_side_model (
	input wire logic hclk,
	output var logic [14:0] ev
);
	timeunit 1ns;
	timeprecision 1ns;
	initial ev = '0;
	// one pulse, high at exactly one sampling edge
	task automatic fire(input int i);
		ev[i] <= 1'b1;
		@(posedge hclk);
		ev[i] <= 1'b0;
	endtask
endmodule

`default_nettype wire

/* File: hw/adapter_error_summary.v */
/*
 * Error summary status block of a system-bus-to-VME adapter: sticky
 * error flags, their mask, vectored and ordinary interrupt requests,
 * read fallback answers and the responder error address lock.
 * Assumes an AHB-Lite master on hclk, event inputs one-cycle pulses
 * on hclk, and the power-fail pin asynchronous and active low.
 */
// Functional notes
// - control state machine in an illegal state sets the internal fault flag
// - page map write data parity error sets internal fault and write failure
// - loopback write parity error aborts write, sets fault and write failure
// - loopback read parity error aborts read and sets internal fault
// - failed I/O write to register or VME space sets write failure
// - write failure with vectored enable issues write-error vectored interrupt
// - write failure set freezes the responder error address
// - power-fail pin assertion sets power-low flag, vectored interrupt if enabled
// - power-low resets to one; also sets on the listed reset events
// - channel A data parity error sets bit 4, vectored interrupt if enabled
// - channel A cmd/addr parity sets bit 3; vectored if write; irq by mask 3
// - channel B data parity error sets bit 2, vectored interrupt if enabled
// - channel B cmd/addr parity sets bit 1; vectored if write; irq by mask 1
// - read data parity error during I/O read or identify sets bit 0
// - read parity error on I/O read answers with read error response
// - read parity error on identify returns the return vector register
// - read parity flag with mask bit 0 raises a system bus interrupt
// - internal fault resets to zero, clears by one, vectored if enabled
`include "adapter_error_summary_regs.vh"
`default_nettype none

module adapter_error_summary (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [11:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire hready,
	input wire [31:0] hwdata,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	input wire ctrl_fsm_illegal,
	input wire page_map_ram_wr_parity_err,
	input wire loopback_mode,
	input wire loopback_wr_parity_err,
	input wire loopback_rd_parity_err,
	input wire io_wr_start,
	input wire [31:0] io_wr_addr,
	input wire io_wr_fail,
	input wire vme_power_fail_input_n,
	input wire power_up_event,
	input wire node_reset_request,
	input wire diag_reset_request,
	input wire vme_boot_reset,
	input wire chan_a_data_parity_err,
	input wire chan_a_cmdaddr_parity_err,
	input wire chan_a_xfer_is_write,
	input wire chan_b_data_parity_err,
	input wire chan_b_cmdaddr_parity_err,
	input wire chan_b_xfer_is_write,
	input wire io_rd_parity_err,
	input wire io_rd_is_ident,
	output reg loopback_wr_abort,
	output reg loopback_rd_abort,
	output reg read_error_response,
	output reg ident_vector_valid,
	output reg [15:0] ident_vector,
	output reg vectored_error_interrupt,
	output reg [3:0] write_error_type_code,
	output reg error_irq
);

	localparam NF = `ESR_NUM_FLAGS;
	// per-flag reset values, one bit each for the sticky cells
	localparam [NF-1:0] FLAG_RST = `ESR_STATUS_RST;
	// bus phase machine states
	localparam ST_IDLE = 2'b00;
	localparam ST_WDATA = 2'b01;
	localparam ST_RDATA = 2'b10;

	reg [1:0] state_reg;
	reg [1:0] state_next;
	reg [11:0] wr_addr_reg;
	reg fsm_bad;
	reg [31:0] error_interrupt_mask_reg;
	reg [15:0] return_vector_reg;
	reg [31:0] resp_err_addr_reg;
	reg a_ca_wr_reg;
	reg b_ca_wr_reg;
	reg pwr_low_seen_reg;
	wire power_fail_level;
	wire [NF-1:0] flag_q;
	reg [NF-1:0] flag_set;
	wire [NF-1:0] flag_clr;
	wire addr_phase;
	wire wr_status;
	wire vec_en;
	wire vec_cause;
	wire irq_cause;
	wire pwr_fail_edge;
	wire [31:0] status_word;

	assign addr_phase = hsel & htrans[1] & hready;
	assign vec_en = error_interrupt_mask_reg[`ESR_MASK_VEC_EN];
	assign status_word = {{(32-NF){1'b0}}, flag_q};

	// power-fail pin crosses into hclk through three stages
	pin_sync3 u_acfail_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.pin(vme_power_fail_input_n),
		.level(power_fail_level)
	);

	// remember the previous synced level to catch the assertion edge
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pwr_low_seen_reg <= 1'b0;
		end else begin
			pwr_low_seen_reg <= ~power_fail_level;
		end
	end
	assign pwr_fail_edge = ~power_fail_level & ~pwr_low_seen_reg;

	// bus phase machine; a stray code is reported as an internal fault
	always @* begin
		state_next = ST_IDLE;
		fsm_bad = 1'b0;
		case (state_reg)
			ST_IDLE, ST_WDATA, ST_RDATA: begin
				if (addr_phase) begin
					state_next = hwrite ? ST_WDATA : ST_RDATA;
				end
			end
			default: begin
				fsm_bad = 1'b1;
			end
		endcase
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= ST_IDLE;
			wr_addr_reg <= 12'h000;
		end else begin
			state_reg <= state_next;
			if (addr_phase) begin
				wr_addr_reg <= haddr;
			end
		end
	end

	// a write of ones to the status word in its data phase clears flags
	assign wr_status = (state_reg == ST_WDATA) && (wr_addr_reg == `ESR_STATUS_OFS);
	assign flag_clr = wr_status ? hwdata[NF-1:0] : {NF{1'b0}};

	// event sources of each flag
	always @* begin
		flag_set = {NF{1'b0}};
		flag_set[`ESR_BIT_INT_FAULT] = ctrl_fsm_illegal | fsm_bad
			| page_map_ram_wr_parity_err
			| (loopback_mode & loopback_wr_parity_err)
			| (loopback_mode & loopback_rd_parity_err);
		flag_set[`ESR_BIT_IO_WR_FAIL] = page_map_ram_wr_parity_err
			| (loopback_mode & loopback_wr_parity_err)
			| io_wr_fail;
		flag_set[`ESR_BIT_PWR_LOW] = pwr_fail_edge
			| power_up_event | node_reset_request
			| diag_reset_request | vme_boot_reset;
		flag_set[`ESR_BIT_A_DATA_PAR] = chan_a_data_parity_err;
		flag_set[`ESR_BIT_A_CA_PAR] = chan_a_cmdaddr_parity_err;
		flag_set[`ESR_BIT_B_DATA_PAR] = chan_b_data_parity_err;
		flag_set[`ESR_BIT_B_CA_PAR] = chan_b_cmdaddr_parity_err;
		flag_set[`ESR_BIT_RD_PAR] = io_rd_parity_err;
	end

	// one sticky cell per flag, reset value taken from the status default
	genvar gi;
	generate
		for (gi = 0; gi < NF; gi = gi + 1) begin : g_flag
			sticky_flag #(
				.RESET_VAL(FLAG_RST[gi])
			) u_flag (
				.hclk(hclk),
				.hresetn(hresetn),
				.set(flag_set[gi]),
				.clr(flag_clr[gi]),
				.q(flag_q[gi])
			);
		end
	endgenerate

	// whether each channel's failing cmd/addr transfer was a write;
	// captured with the error so the vectored request follows it
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			a_ca_wr_reg <= 1'b0;
			b_ca_wr_reg <= 1'b0;
		end else begin
			if (chan_a_cmdaddr_parity_err) begin
				a_ca_wr_reg <= chan_a_xfer_is_write;
			end
			if (chan_b_cmdaddr_parity_err) begin
				b_ca_wr_reg <= chan_b_xfer_is_write;
			end
		end
	end

	// causes of a vectored error interrupt, all gated by the enable
	assign vec_cause = vec_en & (flag_q[`ESR_BIT_IO_WR_FAIL]
		| flag_q[`ESR_BIT_PWR_LOW]
		| flag_q[`ESR_BIT_INT_FAULT]
		| flag_q[`ESR_BIT_A_DATA_PAR]
		| (flag_q[`ESR_BIT_A_CA_PAR] & a_ca_wr_reg)
		| flag_q[`ESR_BIT_B_DATA_PAR]
		| (flag_q[`ESR_BIT_B_CA_PAR] & b_ca_wr_reg));

	// ordinary error interrupt from flags with their own mask bits
	assign irq_cause = (flag_q[`ESR_BIT_RD_PAR] & error_interrupt_mask_reg[0])
		| (flag_q[`ESR_BIT_B_CA_PAR] & error_interrupt_mask_reg[1])
		| (flag_q[`ESR_BIT_A_CA_PAR] & error_interrupt_mask_reg[3]);

	// requests are levels held while a cause stands; the power-low flag
	// comes up set, so software must clear it before enabling vectors
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			vectored_error_interrupt <= 1'b0;
			write_error_type_code <= 4'h0;
			error_irq <= 1'b0;
		end else begin
			vectored_error_interrupt <= vec_cause;
			write_error_type_code <= vec_cause ? `ESR_WR_ERR_TYPE : 4'h0;
			error_irq <= irq_cause;
		end
	end

	// loopback aborts and read fallback answers, one-cycle pulses; ident_vector holds until the next identify error
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			loopback_wr_abort <= 1'b0;
			loopback_rd_abort <= 1'b0;
			read_error_response <= 1'b0;
			ident_vector_valid <= 1'b0;
			ident_vector <= 16'h0000;
		end else begin
			loopback_wr_abort <= loopback_mode & loopback_wr_parity_err;
			loopback_rd_abort <= loopback_mode & loopback_rd_parity_err;
			read_error_response <= io_rd_parity_err & ~io_rd_is_ident;
			ident_vector_valid <= io_rd_parity_err & io_rd_is_ident;
			if (io_rd_parity_err & io_rd_is_ident) begin
				ident_vector <= return_vector_reg;
			end
		end
	end

	// responder error address follows each I/O write start but holds
	// while the write failure flag stands, so the failing address stays
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			resp_err_addr_reg <= 32'h00000000;
		end else if (io_wr_start && !flag_q[`ESR_BIT_IO_WR_FAIL]) begin
			resp_err_addr_reg <= io_wr_addr;
		end
	end

	// mask and return vector registers, written in the data phase
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			error_interrupt_mask_reg <= `ESR_MASK_RST;
			return_vector_reg <= `ESR_RETVEC_RST;
		end else if (state_reg == ST_WDATA) begin
			if (wr_addr_reg == `ESR_MASK_OFS) begin
				error_interrupt_mask_reg <= hwdata & `ESR_MASK_USED;
			end
			if (wr_addr_reg == `ESR_RETVEC_OFS) begin
				return_vector_reg <= hwdata[15:0];
			end
		end
	end

	// read data are loaded at the address phase and stand in the data
	// phase; unmapped offsets read zero and writes there are dropped
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1; // no wait states
			hresp <= 1'b0; // always OKAY
			if (addr_phase && !hwrite) begin
				case (haddr)
					`ESR_STATUS_OFS: hrdata <= status_word;
					`ESR_MASK_OFS: hrdata <= error_interrupt_mask_reg;
					`ESR_RETVEC_OFS: hrdata <= {16'h0000, return_vector_reg};
					`ESR_RESP_ADDR_OFS: hrdata <= resp_err_addr_reg;
					default: hrdata <= 32'h00000000;
				endcase
			end
		end
	end

endmodule

`default_nettype wire

/* File: hw/adapter_error_summary_regs.vh */
/*
 * Register map, field positions, reset values and codes of the
 * adapter error summary block.
 * Assumes inclusion by bare name from the design files under hw/.
 */
`ifndef ADAPTER_ERROR_SUMMARY_REGS_VH
`define ADAPTER_ERROR_SUMMARY_REGS_VH

// byte offsets of the word registers on the register bus
`define ESR_STATUS_OFS 12'h000
`define ESR_MASK_OFS 12'h004
`define ESR_RETVEC_OFS 12'h008
`define ESR_RESP_ADDR_OFS 12'h00c

// error summary status bit positions
`define ESR_BIT_RD_PAR 0
`define ESR_BIT_B_CA_PAR 1
`define ESR_BIT_B_DATA_PAR 2
`define ESR_BIT_A_CA_PAR 3
`define ESR_BIT_A_DATA_PAR 4
`define ESR_BIT_PWR_LOW 5
`define ESR_BIT_IO_WR_FAIL 6
`define ESR_BIT_INT_FAULT 7
`define ESR_NUM_FLAGS 8

// status reset value: only the power-low flag comes up set
`define ESR_STATUS_RST 8'h20

// error interrupt mask fields
`define ESR_MASK_VEC_EN 31
`define ESR_MASK_USED 32'h8000000b
`define ESR_MASK_RST 32'h00000000

// return vector register width and reset value
`define ESR_RETVEC_W 16
`define ESR_RETVEC_RST 16'h0000

// type code carried by a vectored error-interrupt transaction
`define ESR_WR_ERR_TYPE 4'h1

`endif

/* File: hw/pin_sync3.v */
/*
 * Three-stage synchroniser for a level from outside the hclk domain.
 * The output changes only when the second and third stages agree.
 * Assumes the pin idles high; reset loads that idle level.
 */
`default_nettype none

module pin_sync3 (
	input wire hclk,
	input wire hresetn,
	input wire pin,
	output reg level
);

	reg meta_reg;
	reg s2_reg;
	reg s3_reg;

	// first stage feeds only the second stage
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta_reg <= 1'b1;
			s2_reg <= 1'b1;
			s3_reg <= 1'b1;
			level <= 1'b1;
		end else begin
			meta_reg <= pin;
			s2_reg <= meta_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg) begin
				level <= s3_reg;
			end
		end
	end

endmodule

`default_nettype wire

/* File: hw/sticky_flag.v */
/*
 * One write-one-to-clear error flag with a configurable reset value.
 * Assumes set and clr are single-cycle terms on hclk.
 */
`default_nettype none

module sticky_flag #(
	parameter RESET_VAL = 1'b0
) (
	input wire hclk,
	input wire hresetn,
	input wire set,
	input wire clr,
	output reg q
);

	// set wins over a clear in the same cycle so no event is lost
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q <= RESET_VAL;
		end else if (set) begin
			q <= 1'b1;
		end else if (clr) begin
			q <= 1'b0;
		end
	end

endmodule

`default_nettype wire
